// ==== rtl/dma_ext_pkg.sv ====
// constants for the transfer engine page and count extension block
package dma_ext_pkg;

	// ----------------------------------------------------------------
	// register offsets in the memory mapped configuration region
	// ----------------------------------------------------------------
	localparam logic [11:0] chan3_page_extension_off  = 12'hd89;
	localparam logic [11:0] chan5_page_extension_off  = 12'hd8a;
	localparam logic [11:0] chan6_page_extension_off  = 12'hd8b;
	localparam logic [11:0] chan7_page_extension_off  = 12'hd8c;
	localparam logic [11:0] chan3_count_extension_off = 12'hd90;
	localparam logic [11:0] chan5_count_extension_off = 12'hd91;
	localparam logic [11:0] chan6_count_extension_off = 12'hd92;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int          nibble_lsb      = 0;
	localparam int          nibble_width    = 4;
	localparam int          low_addr_width  = 24;
	localparam int          low_count_width = 16;
	localparam int          ext_count_width = 8;
	localparam logic [7:0]  page_ext_reset  = 8'h00;
	localparam logic [7:0]  count_ext_reset = 8'h00;

	// channel slot indices for the four enhanced channels
	localparam int          slot_ch3 = 0;
	localparam int          slot_ch5 = 1;
	localparam int          slot_ch6 = 2;
	localparam int          slot_ch7 = 3;
	localparam int          num_slots = 4;

endpackage

// ==== rtl/dma_ext_channel.sv ====
// one enhanced channel: page nibble register, boundary tracking, counter
`timescale 1ns/1ps

module dma_ext_channel #(
	parameter bit HAS_COUNT = 1'b1                       // channel owns a count byte
) (
	input  wire logic        clk,                        // 40 MHz clock
	input  wire logic        rstn,                       // async reset, active low
	input  wire logic        enhanced,                   // enhanced mode selected
	input  wire logic        page_wr,                    // write strobe, page register
	input  wire logic        count_wr,                   // write strobe, count register
	input  wire logic [7:0]  wr_data,                    // write data
	input  wire logic        addr_step,                  // one address step this cycle
	input  wire logic        addr_down,                  // step direction is decrement
	input  wire logic [23:0] low_addr,                   // page and memory address now
	input  wire logic        count_load,                 // load counter at transfer start
	input  wire logic [15:0] low_count,                  // low count from base register
	input  wire logic        count_step,                 // one transfer completed
	output logic      [7:0]  page_reg,                   // page extension register
	output logic      [7:0]  count_reg,                  // count extension register
	output logic      [27:0] full_addr,                  // 28-bit memory address
	output logic      [23:0] counter_reg,                // running transfer counter
	output logic             terminal                    // counter has expired
);

	logic wrap_up;
	logic wrap_down;
	logic [23:0] load_value;

	// ----------------------------------------------------------------
	// boundary detection
	// ----------------------------------------------------------------
	// a step crosses 16 Mbyte when the low 24 bits are about to wrap
	assign wrap_up   = addr_step && !addr_down && (low_addr == 24'hffffff);
	assign wrap_down = addr_step &&  addr_down && (low_addr == 24'h000000);

	// ----------------------------------------------------------------
	// page extension register
	// ----------------------------------------------------------------
	// a software write wins over a carry in the same cycle; upper bits
	// are stored as written so software can read them back
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			page_reg <= dma_ext_pkg::page_ext_reset;
		end else if (page_wr) begin
			page_reg <= wr_data;
		end else if (enhanced && wrap_up) begin
			page_reg[3:0] <= page_reg[3:0] + 4'h1;
		end else if (enhanced && wrap_down) begin
			page_reg[3:0] <= page_reg[3:0] - 4'h1;
		end
		// normal mode: no carry or borrow reaches the nibble
	end

	// nibble on top of the page and memory address bits
	assign full_addr = {page_reg[3:0], low_addr};

	// ----------------------------------------------------------------
	// count extension register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= dma_ext_pkg::count_ext_reset;
		end else if (HAS_COUNT && count_wr) begin
			count_reg <= wr_data;
		end
	end

	// ----------------------------------------------------------------
	// transfer counter
	// ----------------------------------------------------------------
	// normal mode drops the extension byte and counts 16 bits only
	always_comb begin
		if (HAS_COUNT && enhanced) begin
			load_value = {count_reg, low_count};
		end else begin
			load_value = {8'h00, low_count};
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			counter_reg <= 24'h000000;
		end else if (count_load) begin
			counter_reg <= load_value;
		end else if (count_step && !terminal) begin
			counter_reg <= counter_reg - 24'h000001;
		end
	end

	// count of n expires after n steps; zero alone is the end, no step needed
	assign terminal = (counter_reg == 24'h000000);

endmodule

// ==== rtl/dma_ext_top.sv ====
// page and count extension registers for the enhanced transfer channels
//
// Overview of operation
// - each of channels 3, 5, 6 and 7 has a page nibble in bits 3-0 that gives address bits 27-24.
// - the full address is the nibble joined above the 24 page and memory address bits.
// - in enhanced mode a 16 Mbyte crossing steps the page nibble up or down with the address.
// - in normal mode the page nibble keeps its programmed value with no carry or borrow.
// - channels 3, 5 and 6 have a count byte that gives counter bits 23-16.
// - in enhanced mode the count byte and 16-bit low count form one 24-bit counter.
// - in normal mode the count byte is ignored and only the 16-bit low count is used.
// - enhanced behaviour applies only while the enhanced mode enable bit is set.
`timescale 1ns/1ps

module dma_ext_top (
	input  wire logic        clk,                        // 40 MHz clock
	input  wire logic        rstn,                       // async reset, active low
	input  wire logic [11:0] cfg_addr,                   // config region byte offset
	input  wire logic        cfg_wr,                     // byte write strobe
	input  wire logic        cfg_rd,                     // byte read strobe
	input  wire logic [7:0]  cfg_wdata,                  // write data
	output logic      [7:0]  cfg_rdata,                  // read data, registered
	output logic             cfg_hit,                    // registered: last read decoded here
	input  wire logic        enhanced_mode_enable,       // bit from transfer_global_control
	input  wire logic [3:0]  addr_step,                  // per slot: address stepped
	input  wire logic [3:0]  addr_down,                  // per slot: step is a decrement
	input  wire logic [23:0] low_addr_ch3,               // channel 3 page and memory addr
	input  wire logic [23:0] low_addr_ch5,               // channel 5 page and memory addr
	input  wire logic [23:0] low_addr_ch6,               // channel 6 page and memory addr
	input  wire logic [23:0] low_addr_ch7,               // channel 7 page and memory addr
	input  wire logic [3:0]  count_load,                 // per slot: load counter
	input  wire logic [15:0] low_count_ch3,              // chan3_low_count_register
	input  wire logic [15:0] low_count_ch5,              // chan5_low_count_register
	input  wire logic [15:0] low_count_ch6,              // chan6_low_count_register
	input  wire logic [15:0] low_count_ch7,              // channel 7 low count
	input  wire logic [3:0]  count_step,                 // per slot: transfer done
	output logic      [27:0] mem_addr_ch3,               // 28-bit address, channel 3
	output logic      [27:0] mem_addr_ch5,               // 28-bit address, channel 5
	output logic      [27:0] mem_addr_ch6,               // 28-bit address, channel 6
	output logic      [27:0] mem_addr_ch7,               // 28-bit address, channel 7
	output logic      [23:0] chan3_transfer_counter,     // running counter, channel 3
	output logic      [23:0] chan5_transfer_counter,     // running counter, channel 5
	output logic      [23:0] chan6_transfer_counter,     // running counter, channel 6
	output logic      [23:0] chan7_transfer_counter,     // running counter, channel 7
	output logic      [3:0]  count_done                  // per slot: counter expired
);

	logic [7:0]  page_regs  [4];
	logic [7:0]  count_regs [4];
	logic [23:0] low_addrs  [4];
	logic [15:0] low_counts [4];
	logic [27:0] full_addrs [4];
	logic [23:0] counters   [4];
	logic [3:0]  page_sel;
	logic [3:0]  count_sel;
	logic [7:0]  rdata_next;
	logic        hit_next;
	logic        enhanced_now;

	// ----------------------------------------------------------------
	// mode bit
	// ----------------------------------------------------------------
	// the control bit lives in another register block on the same
	// clock, so it is used directly without synchronising flops; a
	// retimed copy would let a crossing slip by one cycle after a switch
	assign enhanced_now = enhanced_mode_enable;

	// ----------------------------------------------------------------
	// per-slot input arrays
	// ----------------------------------------------------------------
	assign low_addrs[dma_ext_pkg::slot_ch3]  = low_addr_ch3;
	assign low_addrs[dma_ext_pkg::slot_ch5]  = low_addr_ch5;
	assign low_addrs[dma_ext_pkg::slot_ch6]  = low_addr_ch6;
	assign low_addrs[dma_ext_pkg::slot_ch7]  = low_addr_ch7;
	assign low_counts[dma_ext_pkg::slot_ch3] = low_count_ch3;
	assign low_counts[dma_ext_pkg::slot_ch5] = low_count_ch5;
	assign low_counts[dma_ext_pkg::slot_ch6] = low_count_ch6;
	assign low_counts[dma_ext_pkg::slot_ch7] = low_count_ch7;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// channel 7 has no count byte here, so its count select stays low
	always_comb begin
		page_sel  = 4'h0;
		count_sel = 4'h0;
		case (cfg_addr)
			dma_ext_pkg::chan3_page_extension_off:  page_sel[dma_ext_pkg::slot_ch3] = 1'b1;
			dma_ext_pkg::chan5_page_extension_off:  page_sel[dma_ext_pkg::slot_ch5] = 1'b1;
			dma_ext_pkg::chan6_page_extension_off:  page_sel[dma_ext_pkg::slot_ch6] = 1'b1;
			dma_ext_pkg::chan7_page_extension_off:  page_sel[dma_ext_pkg::slot_ch7] = 1'b1;
			dma_ext_pkg::chan3_count_extension_off: count_sel[dma_ext_pkg::slot_ch3] = 1'b1;
			dma_ext_pkg::chan5_count_extension_off: count_sel[dma_ext_pkg::slot_ch5] = 1'b1;
			dma_ext_pkg::chan6_count_extension_off: count_sel[dma_ext_pkg::slot_ch6] = 1'b1;
			default: begin
				page_sel  = 4'h0;
				count_sel = 4'h0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// channel instances
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < dma_ext_pkg::num_slots; g++) begin : g_slot
			dma_ext_channel #(
				.HAS_COUNT (g != dma_ext_pkg::slot_ch7)
			) u_chan (
				.clk         (clk),
				.rstn        (rstn),
				.enhanced    (enhanced_now),
				.page_wr     (cfg_wr && page_sel[g]),
				.count_wr    (cfg_wr && count_sel[g]),
				.wr_data     (cfg_wdata),
				.addr_step   (addr_step[g]),
				.addr_down   (addr_down[g]),
				.low_addr    (low_addrs[g]),
				.count_load  (count_load[g]),
				.low_count   (low_counts[g]),
				.count_step  (count_step[g]),
				.page_reg    (page_regs[g]),
				.count_reg   (count_regs[g]),
				.full_addr   (full_addrs[g]),
				.counter_reg (counters[g]),
				.terminal    (count_done[g])
			);
		end
	endgenerate

	assign mem_addr_ch3           = full_addrs[dma_ext_pkg::slot_ch3];
	assign mem_addr_ch5           = full_addrs[dma_ext_pkg::slot_ch5];
	assign mem_addr_ch6           = full_addrs[dma_ext_pkg::slot_ch6];
	assign mem_addr_ch7           = full_addrs[dma_ext_pkg::slot_ch7];
	assign chan3_transfer_counter = counters[dma_ext_pkg::slot_ch3];
	assign chan5_transfer_counter = counters[dma_ext_pkg::slot_ch5];
	assign chan6_transfer_counter = counters[dma_ext_pkg::slot_ch6];
	assign chan7_transfer_counter = counters[dma_ext_pkg::slot_ch7];

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// live register values are returned, so stepped nibbles are visible
	always_comb begin
		rdata_next = 8'h00;
		hit_next   = 1'b0;
		for (int i = 0; i < dma_ext_pkg::num_slots; i++) begin
			if (page_sel[i]) begin
				rdata_next = page_regs[i];
				hit_next   = 1'b1;
			end
			if (count_sel[i]) begin
				rdata_next = count_regs[i];
				hit_next   = 1'b1;
			end
		end
	end

	// read data is held until the next read
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_rdata <= 8'h00;
			cfg_hit   <= 1'b0;
		end else if (cfg_rd) begin
			cfg_rdata <= rdata_next;
			cfg_hit   <= hit_next;
		end
	end

endmodule

// ==== sim/dma_ext_top_asserts.sv ====
// concurrent checks on the extension block ports
`timescale 1ns/1ps

module dma_ext_top_asserts (
	input wire logic        clk, rstn, cfg_wr, cfg_rd, cfg_hit,  // clock, reset, bus
	input wire logic        enhanced_mode_enable,                // mode bit
	input wire logic [11:0] cfg_addr,                            // config offset
	input wire logic [7:0]  cfg_wdata, cfg_rdata,                // config data
	input wire logic [3:0]  addr_step, addr_down, count_load,    // slot controls
	input wire logic [3:0]  count_step, count_done,              // slot counters
	input wire logic [23:0] low_addr_ch3, low_addr_ch7,          // low addresses
	input wire logic [23:0] chan3_transfer_counter,              // channel 3 counter
	input wire logic [15:0] low_count_ch3,                       // channel 3 low count
	input wire logic [27:0] mem_addr_ch3, mem_addr_ch7           // full addresses
);
	// ----------------------------------------------------------------
	// checks, all on the one clock
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire logic [3:0] n3  = mem_addr_ch3[27:24];
	wire logic [3:0] n7  = mem_addr_ch7[27:24];
	// a write wins over a step, so crossings are judged only without one
	wire logic       up3 = addr_step[0] && !addr_down[0] && low_addr_ch3 == 24'hffffff && !cfg_wr;
	wire logic       dn7 = addr_step[3] && addr_down[3] && low_addr_ch7 == 24'h000000 && !cfg_wr;

	a_page_write: assert property (
		cfg_wr && cfg_addr == dma_ext_pkg::chan3_page_extension_off |=> n3 == $past(cfg_wdata[3:0]))
		else $error("page write not seen on top address bits");
	a_addr_join: assert property (
		mem_addr_ch3[23:0] == low_addr_ch3 && mem_addr_ch7[23:0] == low_addr_ch7)
		else $error("low address bits not passed through");
	a_carry_up: assert property (enhanced_mode_enable && up3 |=> n3 == $past(n3) + 4'h1)
		else $error("no carry into page nibble");
	a_borrow_down: assert property (enhanced_mode_enable && dn7 |=> n7 == $past(n7) - 4'h1)
		else $error("no borrow from page nibble");
	a_normal_hold: assert property (
		!enhanced_mode_enable && !cfg_wr |=> $stable(n3) && $stable(n7))
		else $error("page nibble moved in normal mode");
	a_load_normal: assert property (
		!enhanced_mode_enable && count_load[0] |=> chan3_transfer_counter == {8'h00, $past(low_count_ch3)})
		else $error("normal load used the count byte");
	a_load_enh: assert property (
		enhanced_mode_enable && count_load[0] |=> chan3_transfer_counter[15:0] == $past(low_count_ch3))
		else $error("enhanced load lost the low count");
	a_count_step: assert property (
		!count_load[0] && count_step[0] && !count_done[0]
		|=> chan3_transfer_counter == $past(chan3_transfer_counter) - 24'h1)
		else $error("counter did not step by one");
	a_done_zero: assert property (count_done[0] == (chan3_transfer_counter == 24'h0))
		else $error("expiry flag disagrees with counter");
	a_unmapped_read: assert property (
		cfg_rd && cfg_addr == 12'hd93 |=> cfg_rdata == 8'h00 && !cfg_hit)
		else $error("unmapped read returned data");
	a_page_read: assert property (
		cfg_rd && cfg_addr == dma_ext_pkg::chan3_page_extension_off |=> cfg_hit && cfg_rdata[3:0] == $past(n3))
		else $error("page read not live");
	c_carry: cover property (enhanced_mode_enable && up3);
	c_borrow: cover property (enhanced_mode_enable && dn7);
	c_unmapped: cover property (cfg_rd && cfg_addr == 12'hd93);
endmodule

bind dma_ext_top dma_ext_top_asserts chk (.*);

// ==== sim/dma_extended_page_and_count_test.sv ====
// self-checking bench for the page and count extension block
`timescale 1ns/1ps

module dma_extended_page_and_count_test;
	logic        clk, rstn, cfg_wr, cfg_rd, enh, cfg_hit;
	logic [11:0] cfg_addr;
	logic [7:0]  cfg_wdata, cfg_rdata;
	logic [3:0]  step, down, load, cstep, done;
	logic [23:0] la [4];
	logic [15:0] lc [4];
	logic [27:0] ma [4];
	logic [23:0] cnt [4];
	int          bad_count, compares, cycles;
	logic [11:0] offs [7] = '{12'hd89, 12'hd8a, 12'hd8b, 12'hd8c, 12'hd90, 12'hd91, 12'hd92};

	dma_ext_top DUT (.clk(clk), .rstn(rstn), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
		.enhanced_mode_enable(enh), .addr_step(step), .addr_down(down), .low_addr_ch3(la[0]),
		.low_addr_ch5(la[1]), .low_addr_ch6(la[2]), .low_addr_ch7(la[3]), .count_load(load),
		.low_count_ch3(lc[0]), .low_count_ch5(lc[1]), .low_count_ch6(lc[2]),
		.low_count_ch7(lc[3]), .count_step(cstep), .mem_addr_ch3(ma[0]), .mem_addr_ch5(ma[1]),
		.mem_addr_ch6(ma[2]), .mem_addr_ch7(ma[3]), .chan3_transfer_counter(cnt[0]),
		.chan5_transfer_counter(cnt[1]), .chan6_transfer_counter(cnt[2]),
		.chan7_transfer_counter(cnt[3]), .count_done(done));

	// ----------------------------------------------------------------
	// shared tasks, each entered and left at a falling edge
	// ----------------------------------------------------------------
	task automatic chk(input logic [27:0] got, input logic [27:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(negedge clk);
		cfg_wr = 1'b0;
		// idle edge so a following call does not re-raise the strobe at once
		@(negedge clk);
	endtask
	// read data is registered, so it is settled by the next falling edge
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input logic hit);
		cfg_addr = a;
		cfg_rd = 1'b1;
		@(negedge clk);
		cfg_rd = 1'b0;
		@(negedge clk);
		chk(cfg_rdata, exp);
		chk(cfg_hit, hit);
	endtask
	task automatic stp(input int s, input logic dn, input logic [23:0] a);
		la[s] = a;
		down[s] = dn;
		step[s] = 1'b1;
		@(negedge clk);
		step[s] = 1'b0;
		@(negedge clk);
	endtask
	task automatic stop_test();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 7; i++) begin
			rd_chk(offs[i], 8'h00, 1'b1);
			wr(offs[i], (i < 4) ? 8'h0a - 8'(i) : 8'hc0 + 8'(i));
			rd_chk(offs[i], (i < 4) ? 8'h0a - 8'(i) : 8'hc0 + 8'(i), 1'b1);
		end
		for (int i = 0; i < 4; i++) begin
			chk(ma[i], {4'ha - 4'(i), la[i]});
		end
		wr(12'hd93, 8'hff);
		rd_chk(12'hd93, 8'h00, 1'b0);
		$display("register test done");
	endtask
	task automatic t_cross();
		enh = 1'b1;
		wr(offs[0], 8'h02);
		stp(0, 1'b0, 24'hffffff);
		chk(ma[0], {4'h3, 24'hffffff});
		rd_chk(offs[0], 8'h03, 1'b1);
		stp(0, 1'b0, 24'h7fffff);
		chk(ma[0], {4'h3, 24'h7fffff});
		wr(offs[3], 8'h00);
		stp(3, 1'b1, 24'h000000);
		chk(ma[3], {4'hf, 24'h000000});
		enh = 1'b0;
		stp(0, 1'b0, 24'hffffff);
		stp(3, 1'b1, 24'h000000);
		chk(ma[0], {4'h3, 24'hffffff});
		chk(ma[3], {4'hf, 24'h000000});
		$display("crossing test done");
	endtask
	task automatic t_count();
		enh = 1'b1;
		wr(offs[4], 8'h01);
		wr(offs[5], 8'hff);
		lc = '{16'h0002, 16'hffff, 16'h1234, 16'h0005};
		load = 4'hf;
		@(negedge clk);
		load = 4'h0;
		chk(cnt[0], 24'h010002);
		chk(cnt[1], 24'hffffff);
		chk(cnt[2], {8'hc6, 16'h1234});
		chk(cnt[3], 24'h000005);
		enh = 1'b0;
		load = 4'h1;
		@(negedge clk);
		load = 4'h0;
		chk(cnt[0], 24'h000002);
		cstep = 4'h1;
		repeat (3) @(negedge clk);
		cstep = 4'h0;
		chk(cnt[0], 24'h000000);
		chk(done[0], 1'b1);
		chk(done, 4'h1);
		$display("count test done");
	endtask

	// free-running clock, 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// watchdog: the run needs under 80 cycles, so a hang ends here
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 3000) begin
			bad_count++;
			stop_test();
		end
	end
	// main sequence, inputs moved only at falling edges
	initial begin
		{rstn, cfg_wr, cfg_rd, enh, step, down, load, cstep} = '0;
		cfg_addr = 12'h000;
		cfg_wdata = 8'h00;
		for (int i = 0; i < 4; i++) begin
			la[i] = 24'h0abcd0 + 24'(i);
			lc[i] = 16'h0000;
		end
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		t_regs();
		t_cross();
		t_count();
		stop_test();
	end
endmodule
